// ### src/pid_consts.svh
// Constants for the interrupt dispatch block
`ifndef PID_CONSTS_SVH
`define PID_CONSTS_SVH
`define PID_NSRC         7
`define PID_SRC_IN1      3'h0
`define PID_SRC_IN2      3'h1
`define PID_SRC_IN3      3'h2
`define PID_SRC_IN4      3'h3
`define PID_SRC_TMR      3'h4
`define PID_SRC_CNT1     3'h5
`define PID_SRC_CNT2     3'h6
`define PID_SEL_ALL      3'h7
`define PID_MASKABLE     7'h1f
`define PID_TICK_MIN_US  32'h000001f4
`define PID_TICK_MAX_US  32'h002625a0
`define PID_CLK_MHZ      32'h00000064
`define PID_CYC_MAX_US   32'h00002710
`define PID_PRIO_HIGH    2'h2
`define PID_PRIO_MID     2'h1
`define PID_PRIO_LOW     2'h0
`endif

// ### src/pid_pkg.sv
// Types for the interrupt dispatch block
package pid_pkg;
  typedef struct packed {
    logic       valid;
    logic       unmask;
    logic [2:0] sel;
  } pid_mask_cmd_t;
  typedef struct packed {
    logic        start;
    logic        stop;
    logic [31:0] interval_us;
  } pid_tick_cmd_t;
  typedef enum logic [1:0] {
    PID_EDGE_RISE,
    PID_EDGE_FALL,
    PID_EDGE_BOTH
  } pid_edge_t;
endpackage

// ### src/pid_tick_timer.sv
// Periodic tick source with interval range check
`timescale 1ns/1ps
`include "pid_consts.svh"
module pid_tick_timer (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             srst,
  // Command
  input  wire pid_pkg::pid_tick_cmd_t cmd,
  // Status
  output logic                  tick,
  output logic                  running,
  output logic                  error
);
  import pid_pkg::*;

  logic [31:0] ivl_q;
  logic [31:0] us_q;
  logic [7:0]  div_q;
  logic        run_q;
  logic        err_q;
  wire         in_range = cmd.interval_us >= `PID_TICK_MIN_US &&
                          cmd.interval_us <= `PID_TICK_MAX_US;
  wire         us_end   = div_q == 8'(`PID_CLK_MHZ - 1);
  wire         ivl_end  = us_end && us_q == ivl_q - 32'h1;

  always_ff @(posedge clk) begin
    if (srst || cmd.stop) begin
      run_q <= 1'b0;
      err_q <= 1'b0;
      div_q <= 8'h0;
      us_q  <= 32'h0;
      ivl_q <= 32'h0;
      tick  <= 1'b0;
    end else begin
      tick <= run_q && ivl_end;
      if (cmd.start) begin
        run_q <= in_range;
        err_q <= !in_range;
        ivl_q <= cmd.interval_us;
        div_q <= 8'h0;
        us_q  <= 32'h0;
      end else if (run_q) begin
        div_q <= us_end ? 8'h0 : div_q + 8'h1;
        if (us_end) begin
          us_q <= ivl_end ? 32'h0 : us_q + 32'h1;
        end
      end
    end
  end
  assign running = run_q;
  assign error   = err_q;
endmodule // pid_tick_timer

// ### src/pid_dispatch.sv
// Interrupt dispatch with priority preemption and run time watch
`timescale 1ns/1ps
`include "pid_consts.svh"
module pid_dispatch #(
  parameter int unsigned CYC_MAX_US = `PID_CYC_MAX_US
) (
  // Clock and reset
  input  wire logic                  clk,
  input  wire logic                  srst,
  // Run control
  input  wire logic                  run_req,
  output logic                       run_state_q,
  output logic                       overrun_q,
  // Configuration
  input  wire logic [6:0]            src_enable,
  input  wire pid_pkg::pid_edge_t    edge_cfg [4],
  // Field events
  input  wire logic [3:0]            edge_input,
  input  wire logic [1:0]            cnt_match,
  // Program calls
  input  wire pid_pkg::pid_mask_cmd_t mask_cmd,
  input  wire pid_pkg::pid_tick_cmd_t periodic_tick_arm,
  output logic                       tick_err_q,
  // Handler processor side
  output logic                       main_program_run_q,
  output logic                       handler_start_q,
  output logic [2:0]                 handler_routine_q,
  input  wire logic                  handler_done,
  output logic [31:0]                handler_cycles_q,
  // Register port
  input  wire logic [3:0]            reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic [31:0]                reg_rdata_q,
  output logic                       irq_q
);
  import pid_pkg::*;

  if (CYC_MAX_US == 0 || CYC_MAX_US > 32'hffffffff / `PID_CLK_MHZ) begin : g_bad_cfg
    $error("CYC_MAX_US must be nonzero and fit the cycle counter");
  end

  localparam int unsigned CYC_MAX = CYC_MAX_US * `PID_CLK_MHZ;
  localparam int          N       = `PID_NSRC;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic [1:0] prio_of(input logic [2:0] s);
    if (s == `PID_SRC_IN1 || s == `PID_SRC_IN2) return `PID_PRIO_HIGH;
    if (s == `PID_SRC_IN3 || s == `PID_SRC_IN4) return `PID_PRIO_LOW;
    return `PID_PRIO_MID;
  endfunction

  function automatic logic [6:0] sel_bits(input logic [2:0] s);
    if (s == `PID_SEL_ALL) return `PID_MASKABLE;
    return 7'(7'h1 << s) & `PID_MASKABLE;
  endfunction

  // ----------------------------------------
  // State
  // ----------------------------------------
  logic [3:0]  in_prev_q;
  logic [6:0]  mask_q;
  logic [6:0]  pend_q;
  logic [6:0]  active_q;
  logic [2:0]  stack_q [N];
  logic [2:0]  depth_q;
  logic [31:0] cyc_q;
  logic [6:0]  stat_q;
  logic [6:0]  imask_q;
  logic        run_req_q;

  // ----------------------------------------
  // Timer
  // ----------------------------------------
  wire tick;
  wire tick_running;
  wire tick_error;
  pid_tick_timer u_tick (
    .clk     (clk),
    .srst    (srst),
    .cmd     (periodic_tick_arm),
    .tick    (tick),
    .running (tick_running),
    .error   (tick_error)
  );

  // ----------------------------------------
  // Request detection
  // ----------------------------------------
  logic [3:0] edge_hit;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      unique case (edge_cfg[i])
        PID_EDGE_RISE: edge_hit[i] = edge_input[i] && !in_prev_q[i];
        PID_EDGE_FALL: edge_hit[i] = !edge_input[i] && in_prev_q[i];
        PID_EDGE_BOTH: edge_hit[i] = edge_input[i] != in_prev_q[i];
        default:       edge_hit[i] = 1'b0;
      endcase
    end
  end

  wire        running   = run_state_q;
  wire [6:0]  raw_req   = {cnt_match, tick, edge_hit};
  wire [6:0]  new_req   = raw_req & src_enable & ~mask_q & {N{running}};
  wire [6:0]  all_req   = new_req | pend_q;
  wire [2:0]  cur       = depth_q == 3'h0 ? 3'h0 : stack_q[depth_q - 3'h1];
  wire        busy      = depth_q != 3'h0;
  wire [1:0]  cur_prio  = prio_of(cur);

  // Pick highest priority waiting source not already running
  logic [2:0] pick;
  logic       pick_ok;
  always_comb begin
    pick    = 3'h0;
    pick_ok = 1'b0;
    for (int i = N - 1; i >= 0; i--) begin
      if (all_req[i] && !active_q[i] &&
          (!pick_ok || prio_of(3'(i)) >= prio_of(pick))) begin
        pick    = 3'(i);
        pick_ok = 1'b1;
      end
    end
  end

  // Same channel waits; higher or same priority group preempts, lower waits
  wire start  = pick_ok && running &&
                (!busy || prio_of(pick) >= cur_prio) && !handler_done;
  wire finish = busy && handler_done;
  wire over   = busy && cyc_q >= CYC_MAX;
  // Stop after overrun holds until a fresh run request
  wire run_rise = run_req && !run_req_q;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  wire wr_stat  = reg_wr && reg_addr == 4'h1;
  wire wr_imask = reg_wr && reg_addr == 4'h2;
  wire tick_evt = tick_error && !tick_err_q;
  wire [6:0] ev_set = {3'h0, tick_evt, over, start, finish};

  always_ff @(posedge clk) begin
    if (srst) begin
      in_prev_q <= 4'h0;
    end else begin
      in_prev_q <= edge_input;
    end
  end

  // Mask commands
  always_ff @(posedge clk) begin
    if (srst) begin
      mask_q <= 7'h0;
    end else if (mask_cmd.valid) begin
      if (mask_cmd.unmask) begin
        mask_q <= mask_q & ~sel_bits(mask_cmd.sel);
      end else begin
        mask_q <= mask_q | sel_bits(mask_cmd.sel);
      end
    end
  end

  // Run state
  always_ff @(posedge clk) begin
    if (srst) begin
      run_state_q <= 1'b0;
      overrun_q   <= 1'b0;
      run_req_q   <= 1'b0;
    end else begin
      run_req_q <= run_req;
      if (over) begin
        run_state_q <= 1'b0;
        overrun_q   <= 1'b1;
      end else if (overrun_q && !run_rise) begin
        run_state_q <= 1'b0;
      end else begin
        run_state_q <= run_req;
        overrun_q   <= 1'b0;
      end
    end
  end

  // Pending and handler stack
  always_ff @(posedge clk) begin
    if (srst || !running) begin
      pend_q   <= 7'h0;
      active_q <= 7'h0;
      depth_q  <= 3'h0;
      for (int i = 0; i < N; i++) begin
        stack_q[i] <= 3'h0;
      end
    end else if (finish) begin
      active_q[cur] <= 1'b0;
      depth_q       <= depth_q - 3'h1;
      pend_q        <= pend_q | new_req;
    end else begin
      pend_q <= (pend_q | new_req) &
                ~(start ? 7'(7'h1 << pick) : 7'h0);
      if (start) begin
        active_q[pick]   <= 1'b1;
        stack_q[depth_q] <= pick;
        depth_q          <= depth_q + 3'h1;
      end
    end
  end

  // Run time watch of the running handler
  always_ff @(posedge clk) begin
    if (srst || start || finish || !busy) begin
      cyc_q <= 32'h0;
    end else begin
      cyc_q <= cyc_q + 32'h1;
    end
  end

  // Outputs to the processor
  always_ff @(posedge clk) begin
    if (srst) begin
      main_program_run_q <= 1'b0;
      handler_start_q    <= 1'b0;
      handler_routine_q  <= 3'h0;
      handler_cycles_q   <= 32'h0;
      tick_err_q         <= 1'b0;
    end else begin
      main_program_run_q <= running && !(busy || start) ;
      handler_start_q    <= start;
      handler_routine_q  <= start ? pick : cur;
      handler_cycles_q   <= cyc_q;
      tick_err_q         <= tick_error;
    end
  end

  // Interrupt status, mask and readback
  always_ff @(posedge clk) begin
    if (srst) begin
      stat_q      <= 7'h0;
      imask_q     <= 7'h0;
      irq_q       <= 1'b0;
      reg_rdata_q <= 32'h0;
    end else begin
      stat_q  <= (stat_q & ~(wr_stat ? reg_wdata[6:0] : 7'h0)) | ev_set;
      imask_q <= wr_imask ? reg_wdata[6:0] : imask_q;
      irq_q   <= |(stat_q & imask_q);
      if (reg_rd) begin
        unique case (reg_addr)
          4'h0:    reg_rdata_q <= {20'h0, depth_q, overrun_q, tick_running, 7'h0}
                                  | {25'h0, mask_q};
          4'h1:    reg_rdata_q <= {25'h0, stat_q};
          4'h2:    reg_rdata_q <= {25'h0, imask_q};
          4'h3:    reg_rdata_q <= {25'h0, pend_q};
          4'h4:    reg_rdata_q <= cyc_q;
          default: reg_rdata_q <= 32'h0;
        endcase
      end else begin
        reg_rdata_q <= 32'h0;
      end
    end
  end
endmodule // pid_dispatch

// ### verification/pid_dispatch_assertions.sv
// Checker for the interrupt dispatch block
`timescale 1ns/1ps
module pid_dispatch_checker #(
  parameter int unsigned CYC_MAX_US = 1
) (
  // Clock and reset
  input wire logic        clk,
  input wire logic        srst,
  // Observed ports
  input wire logic        run_state_q,
  input wire logic        overrun_q,
  input wire logic [6:0]  src_enable,
  input wire logic        main_program_run_q,
  input wire logic        handler_start_q,
  input wire logic [2:0]  handler_routine_q,
  input wire logic        handler_done,
  input wire logic [31:0] handler_cycles_q,
  input wire logic        irq_q
);
  localparam int unsigned LIM = CYC_MAX_US * 100 + 2;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // Sequences and properties
  // ----------------------------------------
  sequence s_stopped;
    !run_state_q ##1 !run_state_q;
  endsequence
  sequence s_busy;
    run_state_q && !main_program_run_q && !handler_start_q && !handler_done;
  endsequence
  AST_RST_IDLE: assert property ($fell(srst) |-> !handler_start_q && !irq_q && !run_state_q)
    else $error("outputs not idle after reset");
  AST_START_MAIN: assert property (handler_start_q |-> !main_program_run_q)
    else $error("main program runs at handler start");
  AST_STOP_BLOCK: assert property (s_stopped |-> !handler_start_q)
    else $error("handler started in stop state");
  AST_SRC_EN: assert property (handler_start_q |-> src_enable[handler_routine_q])
    else $error("disabled source dispatched");
  AST_SAME_WAIT: assert property (handler_start_q |=> !(handler_start_q &&
    handler_routine_q == $past(handler_routine_q))) else $error("same channel restarted");
  AST_CYC_COUNT: assert property (s_busy ##1 s_busy ##1 s_busy |->
    handler_cycles_q == $past(handler_cycles_q) + 32'h1) else $error("cycle count stuck");
  AST_OVR_STOP: assert property ($rose(overrun_q) |-> ##[0:1] !run_state_q)
    else $error("overrun without stop");
  AST_OVR_LIMIT: assert property (run_state_q && !main_program_run_q |->
    handler_cycles_q <= LIM) else $error("handler ran past limit");
endmodule // pid_dispatch_checker

bind pid_dispatch pid_dispatch_checker #(.CYC_MAX_US(CYC_MAX_US)) i_chk (
  .clk(clk), .srst(srst), .run_state_q(run_state_q), .overrun_q(overrun_q),
  .src_enable(src_enable), .main_program_run_q(main_program_run_q),
  .handler_start_q(handler_start_q), .handler_routine_q(handler_routine_q),
  .handler_done(handler_done), .handler_cycles_q(handler_cycles_q), .irq_q(irq_q));

// ### verification/pid_proc_model.sv
// Handler processor model, newest handler finishes first
`timescale 1ns/1ps
module pid_proc_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       srst,
  // Dispatch side
  input  wire logic       run_state_q,
  input  wire logic       handler_start_q,
  input  wire logic [7:0] hold,
  output logic            handler_done
);
  logic [3:0] depth_q;
  logic [7:0] left_q;
  always_ff @(posedge clk) begin
    handler_done <= 1'b0;
    if (srst || !run_state_q) begin
      depth_q <= 4'h0;
      left_q  <= 8'h0;
    end else if (handler_start_q) begin
      depth_q <= depth_q + 4'h1;
      left_q  <= hold;
    end else if (depth_q != 4'h0) begin
      if (left_q <= 8'h1) begin
        handler_done <= 1'b1;
        depth_q      <= depth_q - 4'h1;
        left_q       <= hold;
      end else begin
        left_q <= left_q - 8'h1;
      end
    end
  end
endmodule // pid_proc_model

// ### verification/pid_dispatch_bench.sv
// Testbench for the interrupt dispatch block
`timescale 1ns/1ps
module pid_dispatch_bench;
  import pid_pkg::*;
  logic          clk = 1'b0, srst = 1'b1, run_req = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
  logic [6:0]    src_enable = 7'h7f;
  logic [3:0]    edge_input = 4'h0, reg_addr = 4'h0;
  logic [1:0]    cnt_match = 2'h0;
  logic [31:0]   reg_wdata = 32'h0, reg_rdata_q, handler_cycles_q;
  logic [7:0]    hold = 8'h19;
  pid_edge_t     edge_cfg [4] = '{default: PID_EDGE_RISE};
  pid_mask_cmd_t mask_cmd = '0;
  pid_tick_cmd_t tick_cmd = '0;
  logic          run_state_q, overrun_q, tick_err_q, main_program_run_q;
  logic          handler_start_q, handler_done, irq_q;
  logic [2:0]    handler_routine_q;
  logic [31:0]   iv [4] = '{32'h1f3, 32'h1f4, 32'h2625a0, 32'h2625a1};
  int            n_fail = 0, checked = 0;
  always #5 clk = ~clk;
  pid_dispatch #(.CYC_MAX_US(1)) i_dut (.clk(clk), .srst(srst), .run_req(run_req),
    .run_state_q(run_state_q), .overrun_q(overrun_q), .src_enable(src_enable),
    .edge_cfg(edge_cfg), .edge_input(edge_input), .cnt_match(cnt_match),
    .mask_cmd(mask_cmd), .periodic_tick_arm(tick_cmd), .tick_err_q(tick_err_q),
    .main_program_run_q(main_program_run_q), .handler_start_q(handler_start_q),
    .handler_routine_q(handler_routine_q), .handler_done(handler_done),
    .handler_cycles_q(handler_cycles_q), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q), .irq_q(irq_q));
  pid_proc_model i_proc (.clk(clk), .srst(srst), .run_state_q(run_state_q),
    .handler_start_q(handler_start_q), .hold(hold), .handler_done(handler_done));
  // ----------------------------------------
  // Access tasks
  // ----------------------------------------
  task automatic chk(input string what, input logic [31:0] e, input logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_wr    <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [31:0] e);
    @(posedge clk);
    reg_addr <= a;
    reg_rd   <= 1'b1;
    @(posedge clk);
    reg_rd <= 1'b0;
    #1 chk("rdata", e, reg_rdata_q);
  endtask
  task automatic see(input logic [2:0] s, input int n, input logic [31:0] e);
    logic [31:0] k;
    k = 32'h0;
    repeat (n) begin
      @(posedge clk);
      #1 if (handler_start_q === 1'b1 && handler_routine_q === s) k++;
    end
    chk("starts", e, k);
  endtask
  task automatic fire(input logic [2:0] s, input logic [31:0] e);
    @(posedge clk);
    edge_input[s[1:0]] <= 1'b1;
    see(s, 4, e);
    @(posedge clk);
    edge_input[s[1:0]] <= 1'b0;
  endtask
  task automatic msk(input logic u, input logic [2:0] s);
    @(posedge clk);
    mask_cmd <= '{1'b1, u, s};
    @(posedge clk);
    mask_cmd <= '0;
  endtask
  task automatic wrap_up;
    $display("Comparisons %0d, mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    #200000;
    n_fail++;
    wrap_up();
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial begin
    cyc(3);
    srst <= 1'b0;
    cyc(6);
    wr(4'h1, 32'hf);
    wr(4'h2, 32'h2);
    fire(3'h2, 1);
    #1 chk("cycles", 32'h3, handler_cycles_q);
    cyc(30);
    rd(4'h1, 32'h3);
    chk("main", 1, main_program_run_q);
    chk("irq", 1, irq_q);
    wr(4'h2, 32'h0);
    cyc(2);
    #1 chk("irq", 0, irq_q);
    wr(4'h2, 32'h2);
    cyc(2);
    #1 chk("irq", 1, irq_q);
    wr(4'h1, 32'h3);
    cyc(2);
    #1 chk("irq", 0, irq_q);
    rd(4'hf, 32'h0);
    fire(3'h3, 1);
    fire(3'h0, 1);
    fire(3'h0, 0);
    fire(3'h0, 0);
    rd(4'h3, 32'h1);
    see(3'h0, 40, 1);
    cyc(60);
    fire(3'h0, 1);
    fire(3'h3, 0);
    see(3'h3, 40, 1);
    cyc(40);
    @(posedge clk);
    src_enable <= 7'h7b;
    fire(3'h2, 0);
    @(posedge clk);
    src_enable <= 7'h7f;
    for (int i = 0; i < 5; i++) begin
      msk(1'b0, i[2:0]);
      rd(4'h0, 32'h1 << i);
      msk(1'b1, i[2:0]);
    end
    msk(1'b0, 3'h1);
    fire(3'h1, 0);
    msk(1'b1, 3'h1);
    fire(3'h1, 1);
    cyc(30);
    msk(1'b0, 3'h7);
    rd(4'h0, 32'h1f);
    fire(3'h0, 0);
    msk(1'b1, 3'h7);
    fire(3'h0, 1);
    cyc(60);
    fire(3'h0, 1);
    fire(3'h0, 0);
    @(posedge clk);
    run_req <= 1'b0;
    cyc(5);
    fire(3'h1, 0);
    @(posedge clk);
    run_req <= 1'b1;
    see(3'h0, 40, 0);
    @(posedge clk);
    hold <= 8'hc8;
    fire(3'h1, 1);
    cyc(110);
    #1 chk("overrun", 1, overrun_q);
    chk("run", 0, run_state_q);
    @(posedge clk);
    hold    <= 8'h19;
    run_req <= 1'b0;
    cyc(2);
    run_req <= 1'b1;
    cyc(6);
    @(posedge clk);
    edge_cfg <= '{PID_EDGE_FALL, PID_EDGE_BOTH, PID_EDGE_RISE, PID_EDGE_RISE};
    fire(3'h0, 0);
    see(3'h0, 4, 1);
    cyc(40);
    fire(3'h1, 1);
    see(3'h1, 40, 1);
    cyc(30);
    @(posedge clk);
    cnt_match <= 2'h2;
    @(posedge clk);
    cnt_match <= 2'h0;
    #1 chk("cnt", 1, handler_start_q === 1'b1 && handler_routine_q === 3'h6);
    cyc(30);
    for (int i = 0; i < 4; i++) begin
      @(posedge clk);
      tick_cmd <= '{1'b1, 1'b0, iv[i]};
      @(posedge clk);
      tick_cmd <= '0;
      cyc(1);
      #1 chk("tick_err", (i == 0 || i == 3), tick_err_q);
      @(posedge clk);
      tick_cmd <= '{1'b0, 1'b1, 32'h0};
      @(posedge clk);
      tick_cmd <= '0;
    end
    wrap_up();
  end
endmodule // pid_dispatch_bench
